// *** dv/sdt_host_model.sv ***
// board test controller model: drives the test clock, mode and data pins
// and the loop-disable pin; assumes the device starts each scan in idle
`timescale 1ns/1ps
`default_nettype none

module sdt_host_model (
    input wire logic clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo_o,
    input wire logic tdo_oe_n,
    output logic dll_disable_n
);
    int oe_errs;
    logic oe_seen;

    // =============================================================
    // pin defaults: test clock parked low, loop held off at power-up
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        dll_disable_n = 1'b0;
        oe_errs = 0;
    end

    // =============================================================
    // one test clock: pins change after the fall, data out read at rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #6 tck = 1'b1;
        q = tdo_o;
        oe_seen = tdo_oe_n;
        #6 tck = 1'b0;
    endtask

    // five ones reach test logic reset, then park in idle
    task automatic reset_tap();
        logic q;
        repeat (5) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask

    // full scan from idle back to idle, lsb first; idle data toggles
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
            if (oe_seen !== 1'b0) oe_errs++;
        end
        step(1'b1, ~tdi, q);
        if (oe_seen !== 1'b1) oe_errs++;
        repeat (3) step(1'b0, ~tdi, q);
    endtask

    // loop pin moves only on a falling edge of the reference clock
    task automatic dll_set(input logic v);
        @(negedge clk);
        dll_disable_n = v;
    endtask
endmodule // sdt_host_model

`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench of the sram test port and loop power-up logic
// assumes sdt_pkg and the design files are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "sdt_cfg.svh"

module testbench;
    import sdt_pkg::*;
    localparam logic [2:0] REV = 3'h5; // arbitrary value
    localparam logic [16:0] PART = 17'h1B2C3; // arbitrary value
    localparam logic [10:0] MAKER = 11'h35A; // arbitrary value
    localparam logic [127:0] IDW = {96'h0, REV, PART, MAKER, `SDT_ID_PRESENT};
    localparam logic [107:0] PINS = {9{12'h5C3}};
    localparam logic [127:0] D1 = {15'h0, 1'b0, {9{12'hA96}}, 4'h9};
    localparam logic [127:0] D2 = {15'h0, 1'b1, {9{12'h3E1}}, 4'h6};
    logic clk, rst, tck, tms, tdi, tdo_o, tdo_oe_n;
    logic [`SDT_PIN_W-1:0] bsr_pin_i, bsr_pin_o;
    logic bsr_extest, q_drv_hiz, dll_disable_n, dll_use_out_clk;
    logic dll_src_out, dll_locked;
    int n_fail, total_checks, cycles;
    real clk_half = 12.5;

    // =============================================================
    // design and controller model
    sdt_tap #(.ID_REV(REV), .ID_PART(PART), .ID_MAKER(MAKER)) u_sdt_tap (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .bsr_pin_i(bsr_pin_i),
        .bsr_pin_o(bsr_pin_o), .bsr_extest(bsr_extest),
        .q_drv_hiz(q_drv_hiz), .dll_disable_n(dll_disable_n),
        .dll_use_out_clk(dll_use_out_clk), .dll_src_out(dll_src_out),
        .dll_locked(dll_locked)
    );
    sdt_host_model u_sdt_host_model (
        .clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
        .tdo_oe_n(tdo_oe_n), .dll_disable_n(dll_disable_n)
    );

    // =============================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #(clk_half) clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            $display("CHECK FAILED run length expected done seen hang");
            conclude();
        end
    end

    // =============================================================
    // report and compare tasks
    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [127:0] exp,
                       input logic [127:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {127'h0, exp}, {127'h0, got});
    endtask

    // =============================================================
    // access tasks: only four of the five defined codes are loaded, identification comes from reset
    task automatic ir(input logic [2:0] code);
        logic [127:0] got;
        u_sdt_host_model.scan(1'b1, 5, {123'h0, code, 2'b10}, got);
        chk("ir capture", {123'h0, 2'b10, `SDT_IR_CAPTURE}, got & 128'h1F);
        repeat (4) @(negedge clk);
    endtask

    // shift len plus four bits: capture first, then the first four bits in
    task automatic dr(input int len, input logic [127:0] din,
                      input logic [127:0] cap);
        logic [127:0] got;
        u_sdt_host_model.scan(1'b0, len + 4, din, got);
        chk("dr capture", cap, got & ((128'h1 << len) - 1));
        chk("dr length", din & 128'hF, (got >> len) & 128'hF);
        repeat (4) @(negedge clk);
    endtask

    // =============================================================
    // main sequence
    initial begin
        rst = 1'b1;
        dll_use_out_clk = 1'b0;
        bsr_pin_i = PINS;
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        fork
            repeat (4) @(negedge clk);
            u_sdt_host_model.reset_tap();
        join
        rst = 1'b0;
        u_sdt_host_model.reset_tap();
        dr(32, 128'h5, IDW);
        ir(SDT_I_SAMPLE);
        dr(109, D1, {19'h0, 1'b1, PINS});
        chk("pin latches", {20'h0, D1[111:4]}, {20'h0, bsr_pin_o});
        chk1("extest flag", 1'b0, bsr_extest);
        chk1("q float", 1'b0, q_drv_hiz);
        ir(SDT_I_EXTEST);
        chk1("extest flag", 1'b1, bsr_extest);
        chk1("q float", 1'b1, q_drv_hiz);
        dr(109, D2, {19'h0, 1'b0, PINS});
        chk("pin latches", {20'h0, D2[111:4]}, {20'h0, bsr_pin_o});
        chk1("q float", 1'b0, q_drv_hiz);
        ir(SDT_I_SAMPLE_Z);
        chk1("q float", 1'b1, q_drv_hiz);
        dr(109, D1, {19'h0, 1'b1, PINS});
        chk("pin latches", {20'h0, D2[111:4]}, {20'h0, bsr_pin_o});
        ir(SDT_I_BYPASS);
        chk1("q float", 1'b0, q_drv_hiz);
        dr(1, 128'hB, 128'h0);
        ir(SDT_I_SAMPLE);
        dr(109, D1, {19'h0, 1'b1, PINS});
        ir(SDT_I_EXTEST);
        chk1("q float", 1'b1, q_drv_hiz);
        u_sdt_host_model.reset_tap();
        repeat (4) @(negedge clk);
        chk1("extest flag", 1'b0, bsr_extest);
        chk1("q float", 1'b0, q_drv_hiz);
        dr(32, 128'hA, IDW);
        chk("out enable", 128'h0, 128'(u_sdt_host_model.oe_errs));
        // loop power-up on the output clock pair, reference at twice its earlier rate
        clk_half = 6.25;
        dll_use_out_clk = 1'b1;
        repeat (16) @(negedge clk);
        u_sdt_host_model.dll_set(1'b1);
        repeat (1023) @(negedge clk);
        chk1("loop lock early", 1'b0, dll_locked);
        for (int i = 0; i < 8 && dll_locked !== 1'b1; i++) @(negedge clk);
        chk1("loop locked", 1'b1, dll_locked);
        chk1("loop source", 1'b1, dll_src_out);
        u_sdt_host_model.dll_set(1'b0);
        dll_use_out_clk = 1'b0;
        repeat (6) @(negedge clk);
        chk1("loop unlocked", 1'b0, dll_locked);
        chk1("loop source", 1'b0, dll_src_out);
        conclude();
    end
endmodule // testbench

`default_nettype wire

// *** rtl/sdt_cfg.svh ***
// constants of the sram test port and dll power-up block
// assumes inclusion by bare name from the package and the design files
`ifndef SDT_CFG_SVH
`define SDT_CFG_SVH

// =============================================================
// scan register sizes
`define SDT_IR_W 3
`define SDT_BYP_W 1
`define SDT_ID_W 32
`define SDT_BSR_LEN 109
`define SDT_PIN_W 108
`define SDT_OE_CELL 108

// =============================================================
// identification word fields
`define SDT_ID_REV_HI 31
`define SDT_ID_REV_LO 29
`define SDT_ID_PART_HI 28
`define SDT_ID_PART_LO 12
`define SDT_ID_MAKER_HI 11
`define SDT_ID_MAKER_LO 1
`define SDT_ID_PRESENT 1'h1

// =============================================================
// reset values and dll timing
`define SDT_IR_CAPTURE 3'h1
`define SDT_OE_CELL_RST 1'h1
`define SDT_DLL_LOCK_CYC 1024
`define SDT_DLL_CNT_W 11

`endif

// *** rtl/sdt_pkg.sv ***
// types of the sram test port: controller states and instruction codes
// assumes sdt_cfg.svh is on the include path
`include "sdt_cfg.svh"

package sdt_pkg;

    // =============================================================
    // test access port controller states
    typedef enum logic [3:0] {
        SDT_TLR = 4'h0, SDT_RTI = 4'h1, SDT_SEL_DR = 4'h2,
        SDT_CAP_DR = 4'h3, SDT_SH_DR = 4'h4, SDT_EX1_DR = 4'h5,
        SDT_PA_DR = 4'h6, SDT_EX2_DR = 4'h7, SDT_UPD_DR = 4'h8,
        SDT_SEL_IR = 4'h9, SDT_CAP_IR = 4'hA, SDT_SH_IR = 4'hB,
        SDT_EX1_IR = 4'hC, SDT_PA_IR = 4'hD, SDT_EX2_IR = 4'hE,
        SDT_UPD_IR = 4'hF
    } sdt_state_t;

    // =============================================================
    // instruction codes
    typedef enum logic [`SDT_IR_W-1:0] {
        SDT_I_EXTEST = 3'h0, SDT_I_IDCODE = 3'h1, SDT_I_SAMPLE_Z = 3'h2,
        SDT_I_RSV3 = 3'h3, SDT_I_SAMPLE = 3'h4, SDT_I_RSV5 = 3'h5,
        SDT_I_RSV6 = 3'h6, SDT_I_BYPASS = 3'h7
    } sdt_instr_t;

endpackage

// *** rtl/sdt_sync.sv ***
// two flip-flop level synchroniser, parameterised width
// assumes inputs are levels from another clock domain or pins
`timescale 1ns/1ps
`default_nettype none

module sdt_sync
    import sdt_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // =============================================================
    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule // sdt_sync

`default_nettype wire

// *** rtl/sdt_tap.sv ***
// test access port and dll power-up logic of a ddr sram
// assumes tck is free of clk; pins arrive asynchronously to both clocks
`timescale 1ns/1ps
`default_nettype none
`include "sdt_cfg.svh"

// Notes on behaviour
// - instruction 3 bits, bypass 1, identification 32, boundary 109 cells.
// - code 000 captures the I/O ring into the boundary register path.
// - code 001 selects the identification word, memory untouched.
// - code 010 captures pins, selects boundary path, floats data drivers.
// - code 100 captures pins and selects boundary path, memory untouched.
// - code 111 puts the one-bit bypass between serial in and out.
// - id word: revision 31:29, part 28:12, maker 11:1, bit 0 one.
// - mode select and data in are sampled on rising test clock.
// - serial data out changes only after the falling test clock.
// - loop locks 1024 stable clocks after loop-disable goes high.
// - loop follows either the input or the output clock pair.
// - internal cell 108 under external test enables or floats outputs.
// - power-up and test logic reset make identification active.
// - output-enable cell presets high at power-up and test logic reset.
module sdt_tap
    import sdt_pkg::*;
#(
    parameter logic [2:0] ID_REV = 3'h2, // arbitrary value
    parameter logic [16:0] ID_PART = 17'h0ABCD, // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h2A5 // arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_o,
    output logic tdo_oe_n,
    input wire logic [`SDT_PIN_W-1:0] bsr_pin_i,
    output logic [`SDT_PIN_W-1:0] bsr_pin_o,
    output logic bsr_extest,
    output logic q_drv_hiz,
    input wire logic dll_disable_n,
    input wire logic dll_use_out_clk,
    output logic dll_src_out,
    output logic dll_locked
);

    // =============================================================
    // declarations
    logic tck_rst;
    sdt_state_t state;
    sdt_instr_t instr_reg;
    logic [`SDT_IR_W-1:0] ir_sh_reg;
    logic [`SDT_BSR_LEN-1:0] dr_reg;
    logic [`SDT_BYP_W-1:0] byp_reg;
    logic [`SDT_BSR_LEN-1:0] upd_reg;
    logic [`SDT_PIN_W-1:0] pin_s;
    logic [`SDT_ID_W-1:0] part_identification_word;
    logic serial_out;
    logic q_hiz_reg;
    logic q_hiz_next;
    logic dll_en_s;
    logic dll_src_s;
    logic [`SDT_DLL_CNT_W-1:0] dll_cnt_reg;

    // boundary register is the serial path for these codes
    function automatic logic sel_bsr(input sdt_instr_t i);
        sel_bsr = (i == SDT_I_EXTEST) || (i == SDT_I_SAMPLE_Z) ||
            (i == SDT_I_SAMPLE);
    endfunction

    // identification register is the serial path
    function automatic logic sel_id(input sdt_instr_t i);
        sel_id = (i == SDT_I_IDCODE);
    endfunction

    // =============================================================
    // crossings into the test clock domain
    sdt_sync #(.WIDTH(1)) u_rst_sync (
        .clk(tck),
        .rst(1'b0),
        .d(rst),
        .q(tck_rst)
    );

    sdt_sync #(.WIDTH(`SDT_PIN_W)) u_pin_sync (
        .clk(tck),
        .rst(tck_rst),
        .d(bsr_pin_i),
        .q(pin_s)
    );

    sdt_tap_fsm u_fsm (
        .tck(tck),
        .rst(tck_rst),
        .tms(tms),
        .state(state)
    );

    // identification word layout, presence bit fixed high
    assign part_identification_word = {ID_REV, ID_PART, ID_MAKER,
        `SDT_ID_PRESENT};

    // =============================================================
    // instruction shift register: capture pattern then shift lsb first
    always_ff @(posedge tck) begin
        if (tck_rst) begin
            ir_sh_reg <= `SDT_IR_CAPTURE;
        end else if (state == SDT_CAP_IR) begin
            ir_sh_reg <= `SDT_IR_CAPTURE;
        end else if (state == SDT_SH_IR) begin
            ir_sh_reg <= {tdi, ir_sh_reg[`SDT_IR_W-1:1]};
        end
    end

    // active instruction, identification after reset
    always_ff @(posedge tck) begin
        if (tck_rst || state == SDT_TLR) begin
            instr_reg <= SDT_I_IDCODE;
        end else if (state == SDT_UPD_IR) begin
            instr_reg <= sdt_instr_t'(ir_sh_reg);
        end
    end

    // =============================================================
    // shared data shift register for boundary and identification
    always_ff @(posedge tck) begin
        if (tck_rst) begin
            dr_reg <= '0;
        end else if (state == SDT_CAP_DR) begin
            if (sel_bsr(instr_reg)) begin
                // ring snapshot plus internal enable cell
                dr_reg <= {upd_reg[`SDT_OE_CELL], pin_s};
            end else if (sel_id(instr_reg)) begin
                dr_reg <= `SDT_BSR_LEN'(part_identification_word);
            end
        end else if (state == SDT_SH_DR) begin
            if (sel_bsr(instr_reg)) begin
                dr_reg <= {tdi, dr_reg[`SDT_BSR_LEN-1:1]};
            end else if (sel_id(instr_reg)) begin
                dr_reg[`SDT_ID_W-1:0] <= {tdi, dr_reg[`SDT_ID_W-1:1]};
            end
        end
    end

    // bypass cell, also serves the unimplemented codes
    always_ff @(posedge tck) begin
        if (tck_rst) begin
            byp_reg <= '0;
        end else if (state == SDT_CAP_DR) begin
            byp_reg <= '0;
        end else if (state == SDT_SH_DR) begin
            byp_reg <= tdi;
        end
    end

    // =============================================================
    // update latches of the boundary cells, enable cell presets high
    always_ff @(posedge tck) begin
        if (tck_rst || state == SDT_TLR) begin
            upd_reg <= {`SDT_OE_CELL_RST, `SDT_PIN_W'(0)};
        end else if (state == SDT_UPD_DR && (instr_reg == SDT_I_EXTEST ||
                instr_reg == SDT_I_SAMPLE)) begin
            upd_reg <= dr_reg;
        end
    end

    assign bsr_pin_o = upd_reg[`SDT_PIN_W-1:0];
    assign bsr_extest = (instr_reg == SDT_I_EXTEST);

    // data driver float request in the test clock domain
    always_comb begin
        q_hiz_next = (instr_reg == SDT_I_SAMPLE_Z) ||
            (bsr_extest && !upd_reg[`SDT_OE_CELL]);
    end

    always_ff @(posedge tck) begin
        if (tck_rst) begin
            q_hiz_reg <= 1'b0;
        end else begin
            q_hiz_reg <= q_hiz_next;
        end
    end

    // =============================================================
    // serial output mux and falling edge output stage
    always_comb begin
        if (state == SDT_SH_IR) begin
            serial_out = ir_sh_reg[0];
        end else if (sel_bsr(instr_reg) || sel_id(instr_reg)) begin
            serial_out = dr_reg[0];
        end else begin
            serial_out = byp_reg[0];
        end
    end

    always_ff @(negedge tck) begin
        if (tck_rst) begin
            tdo_o <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else begin
            tdo_o <= serial_out;
            tdo_oe_n <= !(state == SDT_SH_DR || state == SDT_SH_IR);
        end
    end

    // =============================================================
    // clk domain: driver float level and dll power-up
    sdt_sync #(.WIDTH(3)) u_clk_sync (
        .clk(clk),
        .rst(rst),
        .d({q_hiz_reg, dll_disable_n, dll_use_out_clk}),
        .q({q_drv_hiz, dll_en_s, dll_src_s})
    );

    // reference pair select held for the loop
    always_ff @(posedge clk) begin
        if (rst) begin
            dll_src_out <= 1'b0;
        end else begin
            dll_src_out <= dll_src_s;
        end
    end

    // lock counter: runs only while the loop is enabled
    always_ff @(posedge clk) begin
        if (rst || !dll_en_s) begin
            dll_cnt_reg <= '0;
            dll_locked <= 1'b0;
        end else if (!dll_locked) begin
            dll_cnt_reg <= dll_cnt_reg + 1'b1;
            dll_locked <= (dll_cnt_reg ==
                `SDT_DLL_CNT_W'(`SDT_DLL_LOCK_CYC - 1));
        end
    end

    // =============================================================
    // checks of the test clock domain
    sequence upd_ir_s;
        state == SDT_UPD_IR;
    endsequence

    ir_reset_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        state == SDT_TLR |=> instr_reg == SDT_I_IDCODE)
        else $error("identification not active after test logic reset");

    oe_preset_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        state == SDT_TLR |=> upd_reg[`SDT_OE_CELL])
        else $error("output enable cell not preset high");

    ir_update_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        upd_ir_s |=> instr_reg == $past(ir_sh_reg))
        else $error("instruction not taken in update-ir");

    ir_capture_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        state == SDT_CAP_IR |=> ir_sh_reg == `SDT_IR_CAPTURE)
        else $error("instruction capture pattern not loaded");

    samplez_hiz_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        instr_reg == SDT_I_SAMPLE_Z |=> q_hiz_reg)
        else $error("drivers not floated under sample-z");

    extest_oe_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        bsr_extest |=> q_hiz_reg == !$past(upd_reg[`SDT_OE_CELL]))
        else $error("enable cell does not steer drivers");

    extest_update_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        state == SDT_UPD_DR && bsr_extest |=> upd_reg == $past(dr_reg))
        else $error("boundary latches not loaded under external test");

    id_capture_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        state == SDT_CAP_DR && sel_id(instr_reg) |=>
            dr_reg[`SDT_ID_W-1:0] == part_identification_word &&
            dr_reg[0])
        else $error("identification word not captured");

    pin_capture_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        state == SDT_CAP_DR && instr_reg == SDT_I_SAMPLE |=>
            dr_reg[`SDT_PIN_W-1:0] == $past(pin_s))
        else $error("pin snapshot not captured");

    bypass_path_a: assert property (
        @(posedge tck) disable iff (tck_rst)
        state == SDT_SH_DR && instr_reg == SDT_I_BYPASS ##1
            state == SDT_SH_DR |-> byp_reg[0] == $past(tdi))
        else $error("bypass cell not between serial in and out");

    // =============================================================
    // checks of the clk domain
    dll_lock_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(dll_locked) |-> $past(dll_cnt_reg) ==
            `SDT_DLL_CNT_W'(`SDT_DLL_LOCK_CYC - 1) && $past(dll_en_s))
        else $error("loop locked after wrong cycle count");

    dll_off_a: assert property (
        @(posedge clk) disable iff (rst)
        !dll_en_s |=> !dll_locked && dll_cnt_reg == '0)
        else $error("loop locked while disabled");

endmodule // sdt_tap

`default_nettype wire

// *** rtl/sdt_tap_fsm.sv ***
// sixteen-state test access port controller
// assumes tck is the test clock and rst a synchronous reset on it
`timescale 1ns/1ps
`default_nettype none

module sdt_tap_fsm
    import sdt_pkg::*;
(
    input wire logic tck,
    input wire logic rst,
    input wire logic tms,
    output sdt_state_t state
);

    sdt_state_t state_next;

    // =============================================================
    // next state from tms
    always_comb begin
        unique case (state)
            SDT_TLR: state_next = tms ? SDT_TLR : SDT_RTI;
            SDT_RTI: state_next = tms ? SDT_SEL_DR : SDT_RTI;
            SDT_SEL_DR: state_next = tms ? SDT_SEL_IR : SDT_CAP_DR;
            SDT_CAP_DR: state_next = tms ? SDT_EX1_DR : SDT_SH_DR;
            SDT_SH_DR: state_next = tms ? SDT_EX1_DR : SDT_SH_DR;
            SDT_EX1_DR: state_next = tms ? SDT_UPD_DR : SDT_PA_DR;
            SDT_PA_DR: state_next = tms ? SDT_EX2_DR : SDT_PA_DR;
            SDT_EX2_DR: state_next = tms ? SDT_UPD_DR : SDT_SH_DR;
            SDT_UPD_DR: state_next = tms ? SDT_SEL_DR : SDT_RTI;
            SDT_SEL_IR: state_next = tms ? SDT_TLR : SDT_CAP_IR;
            SDT_CAP_IR: state_next = tms ? SDT_EX1_IR : SDT_SH_IR;
            SDT_SH_IR: state_next = tms ? SDT_EX1_IR : SDT_SH_IR;
            SDT_EX1_IR: state_next = tms ? SDT_UPD_IR : SDT_PA_IR;
            SDT_PA_IR: state_next = tms ? SDT_EX2_IR : SDT_PA_IR;
            SDT_EX2_IR: state_next = tms ? SDT_UPD_IR : SDT_SH_IR;
            SDT_UPD_IR: state_next = tms ? SDT_SEL_DR : SDT_RTI;
        endcase
    end

    // =============================================================
    // state register, advances on each rising test clock edge
    always_ff @(posedge tck) begin
        if (rst) begin
            state <= SDT_TLR;
        end else begin
            state <= state_next;
        end
    end

endmodule // sdt_tap_fsm

`default_nettype wire
